// [include/cdpm_pkg.sv]
// constants, register map and types for the class-d pwm mode control block
package cdpm_pkg;

   // register offsets
   localparam logic [7:0] OFS_AMP_CONFIG_ONE   = 8'h02;
   localparam logic [7:0] OFS_AMP_CONFIG_TWO   = 8'h03;
   localparam logic [7:0] OFS_LOOP_PHASE_CTL   = 8'h53;
   localparam logic [7:0] OFS_PIN_FUNCTION     = 8'h60;
   localparam logic [7:0] OFS_PIN_INPUT_SEL    = 8'h64;
   localparam logic [7:0] OFS_POWER_STATE      = 8'h68;
   localparam logic [7:0] OFS_MULTI_PHASE      = 8'h6A;
   localparam logic [7:0] OFS_SPREAD_ENABLE    = 8'h6B;
   localparam logic [7:0] OFS_SPREAD_RATE      = 8'h6C;
   localparam logic [7:0] OFS_THERMAL_STATUS   = 8'h73;
   localparam logic [7:0] OFS_FOLDBACK_STEP    = 8'h74;
   localparam logic [7:0] OFS_FOLDBACK_RATE    = 8'h75;

   // reset values
   localparam logic [7:0] RST_AMP_CONFIG_ONE   = 8'h10;
   localparam logic [7:0] RST_AMP_CONFIG_TWO   = 8'h02;
   localparam logic [7:0] RST_ZERO             = 8'h00;
   localparam logic [7:0] RST_FOLDBACK_STEP    = 8'h04;
   localparam logic [7:0] RST_FOLDBACK_RATE    = 8'h44;

   // field positions
   localparam int FSW_LSB        = 4;
   localparam int PHASE_SEL_LSB  = 2;
   localparam int REL_RATE_LSB   = 4;

   // field codes
   localparam logic [1:0] MOD_DIFF      = 2'h0;
   localparam logic [1:0] MOD_LOW_IDLE  = 2'h1;
   localparam logic [1:0] MOD_HYBRID    = 2'h2;
   localparam logic [1:0] REQ_DEEP      = 2'h0;
   localparam logic [1:0] REQ_SLEEP     = 2'h1;
   localparam logic [1:0] REQ_HIZ       = 2'h2;
   localparam logic [1:0] REQ_PLAY      = 2'h3;
   localparam logic [1:0] SPREAD_ON     = 2'h3;
   localparam logic [1:0] SYNC_ON       = 2'h3;
   localparam logic [7:0] SEL_PHASE_SYNC = 8'h01;

   // clock and switching figures
   localparam int CLK_HZ      = 20_000_000;
   localparam int FSW_384_HZ  = 384_000;
   localparam int FSW_480_HZ  = 480_000;
   localparam int FSW_576_HZ  = 576_000;
   localparam int FSW_768_HZ  = 768_000;
   localparam logic [7:0] PER_384 = 8'(CLK_HZ / FSW_384_HZ);
   localparam logic [7:0] PER_480 = 8'(CLK_HZ / FSW_480_HZ);
   localparam logic [7:0] PER_576 = 8'(CLK_HZ / FSW_576_HZ);
   localparam logic [7:0] PER_768 = 8'(CLK_HZ / FSW_768_HZ);

   // modulation figures: idle level in percent, hybrid duty level, phase steps per period
   localparam logic [7:0] IDLE_PCT     = 8'd17;
   localparam logic [7:0] HYB_LEVEL    = 8'd32;
   localparam logic [7:0] PHASE_STEPS  = 8'd8;

   // reported power states
   localparam logic [7:0] RPT_DEEP  = 8'h00;
   localparam logic [7:0] RPT_SLEEP = 8'h01;
   localparam logic [7:0] RPT_HIZ   = 8'h02;
   localparam logic [7:0] RPT_PLAY  = 8'h03;

   typedef enum logic [2:0] {
      PS_DEEP,
      PS_SLEEP,
      PS_HIZ,
      PS_WAIT_SYNC,
      PS_PLAY
   } cdpm_state_type;

endpackage

// [src/cdpm_top.sv]
// pwm carrier, spread spectrum, phase sync, power states and thermal foldback
// Behaviour
// - spread spectrum runs only as triangle; value 0x03 enables both
// - codes 0-3 give 24k triangle, 4-7 give 48k; ranges 5/10/20/25 percent
// - 384 kHz with code 0011 sweeps 25 percent, 336 to 432 kHz
// - bit 0 of loop control enables 180-degree offset between channels
// - four selectable carrier phases, 45 degrees apart, via phase control
// - audio clock restart after hi-z setup aligns carrier phase automatically
// - with pin sync, play request waits in hi-z, reported in power state
// - sync input rising edge moves waiting device into play, phase kept
// - four temperature warning levels read as status bits 0 to 3
// - warnings lower digital gain gradually, higher levels attenuate more
// - below warning level gain ramps back gradually to former setting
// - foldback amount, attack and release rates are programmable
// - code 00 deep sleep, control port alive; 11 returns to play
// - code 01 sleep, control port and digital core keep running
// - code 10 puts only output drivers in hi-z
// - code 11 is normal play with outputs switching
// - two-bit field of config one selects one of three modulations
// - differential: in phase at zero, duties split about 50 percent
// - low-idle: idles near 17 percent, falling side held at ground
// - hybrid adapts duty with signal level
// - config one bits 6 to 4 select switching frequency
`timescale 1ns/100ps
module cdpm_top
   import cdpm_pkg::*;
(
   // clock and reset (power-down pin)
   input  wire logic       clk_i,
   input  wire logic       rst_n_i,
   // control port register access
   input  wire logic [7:0] reg_addr_i,
   input  wire logic [7:0] reg_wdata_i,
   input  wire logic       reg_wr_i,
   output logic      [7:0] reg_rdata_o,
   // external pins
   input  wire logic       audio_clk_run_i,
   input  wire logic       sync_pin_i,
   input  wire logic [3:0] temp_warn_i,
   // sample duty from the dsp, signed
   input  wire logic [7:0] duty_a_i,
   input  wire logic [7:0] duty_b_i,
   // power stage
   output logic      [1:0] out_p_o,
   output logic      [1:0] out_n_o,
   output logic            drv_en_o,
   output logic      [7:0] gain_atten_o,
   output logic      [7:0] carrier_period_o
);
   import cdpm_pkg::*;

   // register storage
   logic [7:0] amp_config_one_q;
   logic [7:0] amp_config_two_q;
   logic [7:0] loop_and_phase_ctl_q;
   logic [7:0] pin_function_ctl_q;
   logic [7:0] pin_input_select_q;
   logic [7:0] multi_phase_select_q;
   logic [7:0] spread_enable_ctl_q;
   logic [7:0] spread_rate_range_q;
   logic [7:0] foldback_step_q;
   logic [7:0] foldback_rate_q;

   // write decode
   wire wr_one_w   = reg_wr_i && (reg_addr_i == OFS_AMP_CONFIG_ONE);
   wire wr_two_w   = reg_wr_i && (reg_addr_i == OFS_AMP_CONFIG_TWO);
   wire wr_loop_w  = reg_wr_i && (reg_addr_i == OFS_LOOP_PHASE_CTL);
   wire wr_pfn_w   = reg_wr_i && (reg_addr_i == OFS_PIN_FUNCTION);
   wire wr_psel_w  = reg_wr_i && (reg_addr_i == OFS_PIN_INPUT_SEL);
   wire wr_phase_w = reg_wr_i && (reg_addr_i == OFS_MULTI_PHASE);
   wire wr_ss0_w   = reg_wr_i && (reg_addr_i == OFS_SPREAD_ENABLE);
   wire wr_ss1_w   = reg_wr_i && (reg_addr_i == OFS_SPREAD_RATE);
   wire wr_fstep_w = reg_wr_i && (reg_addr_i == OFS_FOLDBACK_STEP);
   wire wr_frate_w = reg_wr_i && (reg_addr_i == OFS_FOLDBACK_RATE);

   // control registers stay writable in every power state
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         amp_config_one_q     <= RST_AMP_CONFIG_ONE;
         amp_config_two_q     <= RST_AMP_CONFIG_TWO;
         loop_and_phase_ctl_q <= RST_ZERO;
         pin_function_ctl_q   <= RST_ZERO;
         pin_input_select_q   <= RST_ZERO;
         multi_phase_select_q <= RST_ZERO;
         spread_enable_ctl_q  <= RST_ZERO;
         spread_rate_range_q  <= RST_ZERO;
         foldback_step_q      <= RST_FOLDBACK_STEP;
         foldback_rate_q      <= RST_FOLDBACK_RATE;
      end else begin
         if (wr_one_w)   amp_config_one_q     <= reg_wdata_i;
         if (wr_two_w)   amp_config_two_q     <= reg_wdata_i;
         if (wr_loop_w)  loop_and_phase_ctl_q <= reg_wdata_i;
         if (wr_pfn_w)   pin_function_ctl_q   <= reg_wdata_i;
         if (wr_psel_w)  pin_input_select_q   <= reg_wdata_i;
         if (wr_phase_w) multi_phase_select_q <= reg_wdata_i;
         if (wr_ss0_w)   spread_enable_ctl_q  <= reg_wdata_i;
         if (wr_ss1_w)   spread_rate_range_q  <= reg_wdata_i;
         if (wr_fstep_w) foldback_step_q      <= reg_wdata_i;
         if (wr_frate_w) foldback_rate_q      <= reg_wdata_i;
      end
   end

   // pin synchronisers, first stage read only by the second
   logic [5:0] pin_s1_q;
   logic [5:0] pin_s2_q;
   logic       sync_prev_q;
   logic       clk_run_prev_q;
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pin_s1_q       <= '0;
         pin_s2_q       <= '0;
         sync_prev_q    <= 1'b0;
         clk_run_prev_q <= 1'b0;
      end else begin
         pin_s1_q       <= {audio_clk_run_i, sync_pin_i, temp_warn_i};
         pin_s2_q       <= pin_s1_q;
         sync_prev_q    <= pin_s2_q[4];
         clk_run_prev_q <= pin_s2_q[5];
      end
   end
   wire [3:0] warn_w     = pin_s2_q[3:0];
   wire       sync_rise_w = pin_s2_q[4] && !sync_prev_q;
   wire       clk_rise_w  = pin_s2_q[5] && !clk_run_prev_q;

   // sync configuration decode
   wire       sync_en_w  = (multi_phase_select_q[1:0] == SYNC_ON);
   wire [1:0] phase_sel_w = multi_phase_select_q[PHASE_SEL_LSB +: 2];
   wire       pin_sync_w = sync_en_w && pin_function_ctl_q[0]
                           && (pin_input_select_q == SEL_PHASE_SYNC);

   // power state machine
   cdpm_state_type state_q;
   cdpm_state_type state_d;
   wire [1:0] req_w = amp_config_two_q[1:0];
   always_comb begin
      state_d = state_q;
      case (req_w)
         REQ_DEEP:  state_d = PS_DEEP;
         REQ_SLEEP: state_d = PS_SLEEP;
         REQ_HIZ:   state_d = PS_HIZ;
         REQ_PLAY: begin
            // a pin-synced play request parks in hi-z until the edge
            if (state_q == PS_WAIT_SYNC)
               state_d = sync_rise_w ? PS_PLAY : PS_WAIT_SYNC;
            else if (state_q != PS_PLAY && pin_sync_w)
               state_d = PS_WAIT_SYNC;
            else
               state_d = PS_PLAY;
         end
         default:   state_d = PS_HIZ;
      endcase
   end
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) state_q <= PS_HIZ;
      else          state_q <= state_d;
   end

   // carrier resync: audio clock restart in hi-z, or the sync pin edge
   wire resync_w = (sync_en_w && clk_rise_w && state_q == PS_HIZ)
                   || (state_q == PS_WAIT_SYNC && state_d == PS_PLAY);

   // switching period from config one
   logic [7:0] base_per_w;
   always_comb begin
      case (amp_config_one_q[FSW_LSB +: 3])
         3'h0:    base_per_w = PER_768;
         3'h1:    base_per_w = PER_384;
         3'h2:    base_per_w = PER_480;
         3'h3:    base_per_w = PER_576;
         default: base_per_w = PER_384;
      endcase
   end

   // spread range and triangle rate
   logic [7:0] range_pct_w;
   always_comb begin
      case (spread_rate_range_q[1:0])
         2'h0:    range_pct_w = 8'd5;
         2'h1:    range_pct_w = 8'd10;
         2'h2:    range_pct_w = 8'd20;
         default: range_pct_w = 8'd25;
      endcase
   end
   wire        tri_fast_w = spread_rate_range_q[2];
   wire        spread_on_w = (spread_enable_ctl_q[1:0] == SPREAD_ON);
   // half the range either side of centre: 25 percent of 384 k is 336..432 k
   wire [15:0] span_prod_w = 16'(base_per_w) * 16'(range_pct_w);
   wire [7:0]  span_w      = 8'(span_prod_w / 16'd200);
   // 48 k triangle takes half as many carrier periods, so double the step
   wire [7:0]  step_raw_w  = tri_fast_w ? (span_w >> 1) : (span_w >> 2);
   wire [7:0]  step_w      = (step_raw_w == 8'h00) ? 8'h01 : step_raw_w;

   // triangle offset, signed, stepped once per carrier period
   logic signed [8:0] tri_q;
   logic              tri_up_q;
   logic       [7:0]  cnt_q;
   logic       [7:0]  per_q;
   wire carrier_end_w = (cnt_q >= per_q - 8'h01);
   wire signed [8:0] span_s_w = $signed({1'b0, span_w});
   wire signed [8:0] step_s_w = $signed({1'b0, step_w});
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         tri_q    <= '0;
         tri_up_q <= 1'b1;
      end else if (!spread_on_w) begin
         tri_q    <= '0;
         tri_up_q <= 1'b1;
      end else if (carrier_end_w) begin
         // triangle only: ramp up then down between the span limits
         if (tri_up_q) begin
            if (tri_q + step_s_w >= span_s_w) begin
               tri_q    <= span_s_w;
               tri_up_q <= 1'b0;
            end else begin
               tri_q    <= tri_q + step_s_w;
            end
         end else begin
            if (tri_q - step_s_w <= -span_s_w) begin
               tri_q    <= -span_s_w;
               tri_up_q <= 1'b1;
            end else begin
               tri_q    <= tri_q - step_s_w;
            end
         end
      end
   end

   // phase delay: one eighth of the period per phase step
   wire [15:0] dly_prod_w = 16'(base_per_w) * 16'(phase_sel_w);
   wire [7:0]  dly_w      = 8'(dly_prod_w / 16'(PHASE_STEPS));
   wire [7:0]  load_cnt_w = (dly_w == 8'h00) ? 8'h00 : base_per_w - dly_w;
   wire signed [9:0] next_per_s_w = $signed({2'b00, base_per_w}) + 10'(tri_q);
   wire [7:0]  next_per_w = 8'(next_per_s_w);

   // carrier counter, stopped in deep sleep
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cnt_q <= '0;
         per_q <= PER_384;
      end else if (state_q == PS_DEEP) begin
         cnt_q <= '0;
         per_q <= base_per_w;
      end else if (resync_w) begin
         // every device restarts together, later phases start later
         cnt_q <= load_cnt_w;
         per_q <= base_per_w;
      end else if (carrier_end_w) begin
         cnt_q <= '0;
         per_q <= next_per_w;
      end else begin
         cnt_q <= cnt_q + 8'h01;
      end
   end

   // channel b sits half a period later when the offset is on
   wire [7:0] half_w  = per_q >> 1;
   wire [8:0] cnt_b_sum_w = {1'b0, cnt_q} + {1'b0, half_w};
   wire [7:0] cnt_b_w = loop_and_phase_ctl_q[0]
                        ? ((cnt_b_sum_w >= {1'b0, per_q}) ? 8'(cnt_b_sum_w - {1'b0, per_q})
                                                           : cnt_b_sum_w[7:0])
                        : cnt_q;
   wire [15:0] idle_prod_w = 16'(per_q) * 16'(IDLE_PCT);
   wire [7:0]  idle_th_w   = 8'(idle_prod_w / 16'd100);
   wire [1:0]  mod_sel_w   = amp_config_one_q[1:0];

   // per-channel threshold compare
   logic [1:0] p_lvl_w;
   logic [1:0] n_lvl_w;
   for (genvar ch = 0; ch < 2; ch++) begin : g_ch
      wire [7:0]  duty_w  = (ch == 0) ? duty_a_i : duty_b_i;
      wire [7:0]  cnt_w   = (ch == 0) ? cnt_q : cnt_b_w;
      wire        neg_w   = duty_w[7];
      wire [7:0]  mag_w   = neg_w ? 8'(-duty_w) : duty_w;
      wire [15:0] sc_p_w  = 16'(mag_w) * 16'(half_w);
      wire [7:0]  sc_w    = 8'(sc_p_w >> 7);
      // differential: both at half when idle, split about the middle
      wire [7:0]  bd_hi_w = half_w + sc_w;
      wire [7:0]  bd_lo_w = (sc_w > half_w) ? 8'h00 : half_w - sc_w;
      wire [7:0]  bd_p_w  = neg_w ? bd_lo_w : bd_hi_w;
      wire [7:0]  bd_n_w  = neg_w ? bd_hi_w : bd_lo_w;
      // low idle: the falling side rails low, only the rising one switches
      wire [7:0]  li_w    = idle_th_w + sc_w;
      wire        quiet_w = (mag_w == 8'h00);
      wire [7:0]  li_p_w  = quiet_w ? idle_th_w : (neg_w ? 8'h00 : li_w);
      wire [7:0]  li_n_w  = quiet_w ? idle_th_w : (neg_w ? li_w : 8'h00);
      // hybrid: low idle for small signals, differential once loud
      wire        use_bd_w = (mod_sel_w == MOD_DIFF)
                             || (mod_sel_w == MOD_HYBRID && mag_w >= HYB_LEVEL);
      wire [7:0]  th_p_w  = use_bd_w ? bd_p_w : li_p_w;
      wire [7:0]  th_n_w  = use_bd_w ? bd_n_w : li_n_w;
      assign p_lvl_w[ch] = (cnt_w < th_p_w);
      assign n_lvl_w[ch] = (cnt_w < th_n_w);
   end

   // output stage: only play switches, every other state holds drivers off
   wire play_w = (state_q == PS_PLAY);
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         out_p_o  <= '0;
         out_n_o  <= '0;
         drv_en_o <= 1'b0;
      end else begin
         out_p_o  <= play_w ? p_lvl_w : 2'b00;
         out_n_o  <= play_w ? n_lvl_w : 2'b00;
         drv_en_o <= play_w;
      end
   end

   // thermal foldback target: highest active warning times the step
   logic [2:0] warn_lvl_w;
   always_comb begin
      if (warn_w[3])      warn_lvl_w = 3'd4;
      else if (warn_w[2]) warn_lvl_w = 3'd3;
      else if (warn_w[1]) warn_lvl_w = 3'd2;
      else if (warn_w[0]) warn_lvl_w = 3'd1;
      else                warn_lvl_w = 3'd0;
   end
   wire [10:0] tgt_prod_w = 11'(foldback_step_q) * 11'(warn_lvl_w);
   wire [7:0]  target_w   = (tgt_prod_w > 11'h0FF) ? 8'hFF : tgt_prod_w[7:0];

   // rate tick: one step per 2^rate cycles, attack and release apart
   logic [15:0] rate_cnt_q;
   wire         attack_w  = (target_w > gain_atten_o);
   wire [3:0]   rate_w    = attack_w ? foldback_rate_q[3:0]
                                     : foldback_rate_q[REL_RATE_LSB +: 4];
   wire [15:0]  rate_mask_w = 16'((17'h1 << rate_w) - 17'h1);
   wire         tick_w    = ((rate_cnt_q & rate_mask_w) == rate_mask_w);
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rate_cnt_q   <= '0;
         gain_atten_o <= '0;
      end else begin
         rate_cnt_q <= rate_cnt_q + 16'h0001;
         if (tick_w) begin
            // gradual, one step at a time, so no audible jumps
            if (attack_w)
               gain_atten_o <= gain_atten_o + 8'h01;
            else if (target_w < gain_atten_o)
               gain_atten_o <= gain_atten_o - 8'h01;
         end
      end
   end

   // power state report
   logic [7:0] rpt_w;
   always_comb begin
      case (state_q)
         PS_DEEP:      rpt_w = RPT_DEEP;
         PS_SLEEP:     rpt_w = RPT_SLEEP;
         PS_HIZ:       rpt_w = RPT_HIZ;
         PS_WAIT_SYNC: rpt_w = RPT_HIZ;
         PS_PLAY:      rpt_w = RPT_PLAY;
         default:      rpt_w = RPT_HIZ;
      endcase
   end

   // read mux, unmapped offsets read zero
   logic [7:0] rd_w;
   always_comb begin
      case (reg_addr_i)
         OFS_AMP_CONFIG_ONE: rd_w = amp_config_one_q;
         OFS_AMP_CONFIG_TWO: rd_w = amp_config_two_q;
         OFS_LOOP_PHASE_CTL: rd_w = loop_and_phase_ctl_q;
         OFS_PIN_FUNCTION:   rd_w = pin_function_ctl_q;
         OFS_PIN_INPUT_SEL:  rd_w = pin_input_select_q;
         OFS_POWER_STATE:    rd_w = rpt_w;
         OFS_MULTI_PHASE:    rd_w = multi_phase_select_q;
         OFS_SPREAD_ENABLE:  rd_w = spread_enable_ctl_q;
         OFS_SPREAD_RATE:    rd_w = spread_rate_range_q;
         OFS_THERMAL_STATUS: rd_w = {4'h0, warn_w};
         OFS_FOLDBACK_STEP:  rd_w = foldback_step_q;
         OFS_FOLDBACK_RATE:  rd_w = foldback_rate_q;
         default:            rd_w = 8'h00;
      endcase
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         reg_rdata_o      <= '0;
         carrier_period_o <= PER_384;
      end else begin
         reg_rdata_o      <= rd_w;
         carrier_period_o <= per_q;
      end
   end

endmodule

// [testbench/cdpm_top_sva.sv]
// port-level assertions for the pwm mode control block
`timescale 1ns/100ps
module cdpm_top_sva (
   // clock and reset
   input wire logic       clk_i,
   input wire logic       rst_n_i,
   // register port
   input wire logic [7:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic       reg_wr_i,
   input wire logic [7:0] reg_rdata_o,
   // pins and samples
   input wire logic       audio_clk_run_i,
   input wire logic       sync_pin_i,
   input wire logic [3:0] temp_warn_i,
   input wire logic [7:0] duty_a_i,
   input wire logic [7:0] duty_b_i,
   // power stage
   input wire logic [1:0] out_p_o,
   input wire logic [1:0] out_n_o,
   input wire logic       drv_en_o,
   input wire logic [7:0] gain_atten_o,
   input wire logic [7:0] carrier_period_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   // steps of the behaviours watched below
   sequence spread_wr;
      reg_wr_i && reg_addr_i == 8'h6B;
   endsequence
   sequence spread_look;
      !reg_wr_i && reg_addr_i == 8'h6B;
   endsequence
   sequence warn_steady;
      ($stable(temp_warn_i) && reg_addr_i == 8'h73)[*5];
   endsequence
   sequence state_low;
      reg_wr_i && reg_addr_i == 8'h03 && reg_wdata_i[1:0] != 2'h3;
   endsequence
   // four-cycle lookback, since a state write reaches the drivers three edges later
   sequence no_state_wr;
      (!(reg_wr_i && reg_addr_i == 8'h03))[*4];
   endsequence
   spread_readback_a: assert property (spread_wr ##1 spread_look |=> reg_rdata_o == $past(reg_wdata_i, 2))
      else $error("spread enable readback differs");
   low_state_off_a: assert property (state_low |-> ##3 !drv_en_o)
      else $error("drivers enabled outside play");
   quiet_outputs_a: assert property ((!drv_en_o)[*2] |-> out_p_o == 2'b00 && out_n_o == 2'b00)
      else $error("pwm switching with drivers off");
   thermal_status_a: assert property (warn_steady |-> reg_rdata_o == {4'h0, temp_warn_i})
      else $error("thermal status differs from warning pins");
   gain_gradual_a: assert property ($changed(gain_atten_o) |=> $stable(gain_atten_o)[*4])
      else $error("attenuation moved too fast");
   gain_hold_a: assert property ((temp_warn_i == 4'h0 && gain_atten_o == 8'h00)[*6] |=> gain_atten_o == 8'h00)
      else $error("attenuation without warning");
   play_switch_a: assert property ($rose(drv_en_o) |-> ##[1:200] $changed(out_p_o | out_n_o))
      else $error("no switching after play");
   play_hold_a: assert property (no_state_wr ##0 drv_en_o |=> drv_en_o)
      else $error("play left without state write");
endmodule
bind cdpm_top cdpm_top_sva i_cdpm_top_sva (.clk_i(clk_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i),
   .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rdata_o(reg_rdata_o), .audio_clk_run_i(audio_clk_run_i),
   .sync_pin_i(sync_pin_i), .temp_warn_i(temp_warn_i), .duty_a_i(duty_a_i), .duty_b_i(duty_b_i),
   .out_p_o(out_p_o), .out_n_o(out_n_o), .drv_en_o(drv_en_o), .gain_atten_o(gain_atten_o),
   .carrier_period_o(carrier_period_o));

// [testbench/cdpm_host_gpio.sv]
// host gpio model that gives the phase-sync edge
`timescale 1ns/100ps
module cdpm_host_gpio (
   // clock, reset and bench request
   input  wire logic clk_i,
   input  wire logic rst_n_i,
   input  wire logic sync_req_i,
   // sync pin
   output logic      sync_pin_o
);
   // idles low; follows the request one clock edge later, and drops low again when it drops
   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         sync_pin_o <= 1'b0;
      end else begin
         sync_pin_o <= #2 sync_req_i;
      end
   end
endmodule

// [testbench/tb_top.sv]
// self-checking bench: registers, states, spread, foldback, pin sync
`timescale 1ns/100ps
module tb_top;
   import cdpm_pkg::*;
   logic       clk_i = 1'b0, rst_n_i = 1'b0, reg_wr_i = 1'b0, sync_req = 1'b0, pend = 1'b0;
   logic       clk_run = 1'b1, quiet = 1'b0;
   logic [7:0] reg_addr_i = 8'h00, reg_wdata_i = 8'h00, duty_a_i = 8'h00, duty_b_i = 8'h00;
   logic [3:0] temp_warn_i = 4'h0;
   logic [7:0] reg_rdata_o, gain_atten_o, carrier_period_o, lo, hi, g1, v, exp_q[$];
   logic [1:0] out_p_o, out_n_o;
   logic       drv_en_o, sync_pin_i;
   int         error_cnt = 0, comparisons = 0, cyc = 0, off, c0, n;
   localparam logic [7:0] PER_TAB [4] = '{PER_768, PER_384, PER_480, PER_576};
   localparam logic [7:0] RW_OFS [4] = '{OFS_LOOP_PHASE_CTL, OFS_MULTI_PHASE, OFS_PIN_INPUT_SEL, OFS_SPREAD_RATE};
   localparam int         PCT_TAB [4] = '{5, 10, 20, 25};
   // audio clock runs from reset; the bench halts and restarts it for the clock sync
   cdpm_top i_cdpm_top (.clk_i(clk_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
      .reg_wr_i(reg_wr_i), .reg_rdata_o(reg_rdata_o), .audio_clk_run_i(clk_run), .sync_pin_i(sync_pin_i),
      .temp_warn_i(temp_warn_i), .duty_a_i(duty_a_i), .duty_b_i(duty_b_i), .out_p_o(out_p_o), .out_n_o(out_n_o),
      .drv_en_o(drv_en_o), .gain_atten_o(gain_atten_o), .carrier_period_o(carrier_period_o));
   cdpm_host_gpio i_cdpm_host_gpio (.clk_i(clk_i), .rst_n_i(rst_n_i), .sync_req_i(sync_req), .sync_pin_o(sync_pin_i));
   task automatic summarize();
      if (error_cnt == 0 && comparisons > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
      comparisons++;
      if (got !== exp) begin
         error_cnt++;
         $display("MISMATCH %0t byte %h expected %h", $time, got, exp);
      end
   endtask
   task automatic cmp1(input logic got, input logic exp);
      comparisons++;
      if (got !== exp) begin
         error_cnt++;
         $display("MISMATCH %0t flag %b expected %b", $time, got, exp);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk_i) #2;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      reg_addr_i = a;
      reg_wdata_i = d;
      reg_wr_i = 1'b1;
      tick(1);
      reg_wr_i = 1'b0;
      tick(1);
   endtask
   // read data is registered, so the note is checked one edge after the address
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      reg_addr_i = a;
      exp_q.push_back(e);
      tick(1);
      pend = 1'b1;
      tick(1);
      pend = 1'b0;
   endtask
   always @(negedge clk_i) begin
      if (pend) cmp8(reg_rdata_o, exp_q.pop_front());
   end
   initial begin
      forever #25 clk_i = ~clk_i;
   end
   // random duty each cycle; the ceiling sits well above the expected run length
   always @(posedge clk_i) begin
      cyc <= cyc + 1;
      #2 duty_a_i = quiet ? 8'h00 : 8'($urandom);
      duty_b_i = 8'($urandom);
      if (cyc == 30000) begin
         error_cnt++;
         $display("MISMATCH %0t run did not finish", $time);
         summarize();
      end
   end
   initial begin
      v = 8'($urandom(32'h5155));
      repeat (12) @(posedge clk_i);
      #2 rst_n_i = 1'b1;
      cmp8(carrier_period_o, PER_384);
      rd(OFS_AMP_CONFIG_ONE, RST_AMP_CONFIG_ONE);
      wr(OFS_POWER_STATE, 8'hFF);
      rd(OFS_POWER_STATE, RPT_HIZ);
      foreach (RW_OFS[i]) begin
         v = 8'($urandom);
         wr(RW_OFS[i], v);
         rd(RW_OFS[i], v);
      end
      for (int s = 0; s < 4; s++) begin
         wr(OFS_AMP_CONFIG_TWO, 8'(s));
         tick(3);
         cmp1(drv_en_o, s == 3);
         rd(OFS_POWER_STATE, 8'(s));
      end
      for (int f = 0; f < 4; f++) begin
         wr(OFS_AMP_CONFIG_ONE, 8'(f << FSW_LSB));
         tick(120);
         cmp8(carrier_period_o, PER_TAB[f]);
      end
      wr(OFS_AMP_CONFIG_ONE, RST_AMP_CONFIG_ONE);
      wr(OFS_SPREAD_ENABLE, {6'h00, SPREAD_ON});
      rd(OFS_SPREAD_ENABLE, 8'h03);
      // sweep extremes per range code, at the 384 kHz centre
      for (int c = 0; c < 8; c++) begin
         wr(OFS_SPREAD_RATE, 8'(c));
         off = PER_384 * PCT_TAB[c % 4] / 200;
         tick(600);
         lo = 8'hFF;
         hi = 8'h00;
         repeat (1200) begin
            tick(1);
            if (carrier_period_o < lo) lo = carrier_period_o;
            if (carrier_period_o > hi) hi = carrier_period_o;
         end
         cmp8(lo, 8'(PER_384 - off));
         cmp8(hi, 8'(PER_384 + off));
      end
      wr(OFS_SPREAD_ENABLE, 8'h00);
      temp_warn_i = 4'h1;
      rd(OFS_THERMAL_STATUS, 8'h00);
      tick(600);
      g1 = gain_atten_o;
      cmp1(g1 != 8'h00, 1'b1);
      temp_warn_i = {1'b1, 3'($urandom)};
      tick(600);
      rd(OFS_THERMAL_STATUS, {4'h0, temp_warn_i});
      cmp1(gain_atten_o > g1, 1'b1);
      temp_warn_i = 4'h0;
      tick(600);
      cmp8(gain_atten_o, 8'h00);
      // host halts the audio clock, sets phase 1 and hi-z, then restarts it
      quiet = 1'b1;
      clk_run = 1'b0;
      wr(OFS_AMP_CONFIG_TWO, {6'h00, REQ_HIZ});
      wr(OFS_MULTI_PHASE, 8'h07);
      clk_run = 1'b1;
      c0 = cyc;
      tick(6);
      wr(OFS_AMP_CONFIG_TWO, {6'h00, REQ_PLAY});
      // carrier start: three sync edges, the phase delay, one output edge
      @(negedge out_p_o[0]);
      @(posedge out_p_o[0]);
      #2;
      cmp8(8'((cyc - c0) % PER_384), 8'(4 + PER_384 / PHASE_STEPS));
      // zero duty: differential at half, low idle and quiet hybrid at idle level
      for (int m = 0; m < 3; m++) begin
         wr(OFS_AMP_CONFIG_ONE, RST_AMP_CONFIG_ONE | 8'(m));
         tick(60);
         n = 0;
         repeat (PER_384) begin
            tick(1);
            n += out_p_o[0] + out_n_o[0];
         end
         cmp8(8'(n), 8'(m ? 2 * (int'(PER_384) * IDLE_PCT / 100) : 2 * (PER_384 / 2)));
      end
      wr(OFS_AMP_CONFIG_TWO, {6'h00, REQ_HIZ});
      wr(OFS_PIN_FUNCTION, 8'h01);
      wr(OFS_PIN_INPUT_SEL, SEL_PHASE_SYNC);
      wr(OFS_AMP_CONFIG_TWO, {6'h00, REQ_PLAY});
      tick(4);
      cmp1(drv_en_o, 1'b0);
      rd(OFS_POWER_STATE, RPT_HIZ);
      sync_req = 1'b1;
      tick(8);
      cmp1(drv_en_o, 1'b1);
      rd(OFS_POWER_STATE, RPT_PLAY);
      summarize();
   end
endmodule
